// File: bench/watchdog_timer_sva.sv
`timescale 1ns/1ps
module watchdog_timer_sva (
    input wire logic        aclk,
    input wire logic        aresetn,
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic [1:0]  s_axi_bresp,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    input wire logic        sleep_mode,
    input wire logic        watchdog_reset,
    input wire logic        watchdog_wakeup,
    input wire logic        timeout_status_clear
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    sequence s_wtake; s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready; endsequence
    sequence s_rtake; s_axi_arvalid && s_axi_arready; endsequence
    property p_rst_pulse; watchdog_reset |=> !watchdog_reset; endproperty
    property p_rst_awake; watchdog_reset |-> !$past(sleep_mode) && !watchdog_wakeup; endproperty
    property p_wake_sleep; watchdog_wakeup |-> $past(sleep_mode); endproperty
    property p_wake_pulse; watchdog_wakeup |=> !watchdog_wakeup [*2]; endproperty
    property p_to_clear; timeout_status_clear == (watchdog_reset || watchdog_wakeup); endproperty
    property p_wr_answer; s_wtake |=> s_axi_bvalid; endproperty
    property p_bhold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp); endproperty
    property p_rd_answer; s_rtake |=> s_axi_rvalid; endproperty
    property p_rhold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata); endproperty
    a_rst_pulse: assert property (p_rst_pulse) else $error("reset pulse too long");
    a_rst_awake: assert property (p_rst_awake) else $error("reset while asleep");
    a_wake_sleep: assert property (p_wake_sleep) else $error("wakeup while awake");
    a_wake_pulse: assert property (p_wake_pulse) else $error("wakeup pulse too long");
    a_to_clear: assert property (p_to_clear) else $error("status clear mismatch");
    a_wr_answer: assert property (p_wr_answer) else $error("no write answer");
    a_bhold: assert property (p_bhold) else $error("write answer dropped");
    a_rd_answer: assert property (p_rd_answer) else $error("no read answer");
    a_rhold: assert property (p_rhold) else $error("read answer dropped");
endmodule // watchdog_timer_sva

bind watchdog_timer watchdog_timer_sva u_sva (.*);

// File: bench/watchdog_timer_tb.sv
`timescale 1ns/1ps
module watchdog_timer_tb;
    logic        aclk = 0, aresetn = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
    logic        s_axi_arvalid = 0, s_axi_rready = 0, rc_oscillator = 0, sleep_mode = 0;
    logic        clear_watchdog_instruction = 0, sleep_instruction = 0, config_watchdog_on = 0;
    logic [31:0] s_axi_awaddr = 0, s_axi_wdata = 0, s_axi_araddr = 0, d;
    logic [3:0]  s_axi_wstrb = 4'hf;
    logic [2:0]  configured_postscale_select = 3'h3;
    logic [1:0]  r;
    wire         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
    wire         watchdog_reset, watchdog_wakeup, timeout_status_clear;
    wire [1:0]   s_axi_bresp, s_axi_rresp;
    wire [31:0]  s_axi_rdata;
    int          errors = 0, n_checks = 0, nres = 0, nwak = 0, ntsc = 0, ps;

    watchdog_timer #(.BASE_COUNT(4)) u_dut (.*);

    initial forever #25 aclk = ~aclk;
    always @(posedge aclk) begin
        nres <= nres + watchdog_reset;
        nwak <= nwak + watchdog_wakeup;
        ntsc <= ntsc + timeout_status_clear;
    end

    task wrap_up;
        $display("checks %0d errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    task chk(input logic [31:0] seen, exp);
        n_checks++;
        if (seen !== exp) begin
            errors++;
            $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    // Sampled at the falling edge so the next rising edge is the one that takes or answers
    task wait_for(input int k);
        int n;
        n = 0;
        @(negedge aclk);
        while (!(k == 0 ? s_axi_awready : k == 1 ? s_axi_bvalid : k == 2 ? s_axi_arready : s_axi_rvalid)) begin
            @(negedge aclk);
            n++;
            if (n > 200) begin
                errors++;
                wrap_up();
            end
        end
    endtask
    task wr(input logic [31:0] a, v);
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= v;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        wait_for(0);
        @(posedge aclk);
        s_axi_awvalid <= 1'h0;
        s_axi_wvalid <= 1'h0;
        wait_for(1);
        r = s_axi_bresp;
        // Late ready exercises the slave holding its answer
        @(posedge aclk);
        s_axi_bready <= 1'h1;
        @(posedge aclk);
        s_axi_bready <= 1'h0;
    endtask
    task rd(input logic [31:0] a);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'h1;
        wait_for(2);
        @(posedge aclk);
        s_axi_arvalid <= 1'h0;
        wait_for(3);
        d = s_axi_rdata;
        r = s_axi_rresp;
        @(posedge aclk);
        s_axi_rready <= 1'h1;
        @(posedge aclk);
        s_axi_rready <= 1'h0;
    endtask
    // Oscillator period of 12 cycles leaves room for the synchroniser
    task tick(input int n);
        repeat (n) begin
            @(posedge aclk);
            rc_oscillator <= 1'h1;
            repeat (6) @(posedge aclk);
            rc_oscillator <= 1'h0;
            repeat (5) @(posedge aclk);
        end
        @(negedge aclk);
    endtask
    task pulse(input bit s);
        @(posedge aclk);
        sleep_instruction <= s;
        clear_watchdog_instruction <= !s;
        @(posedge aclk);
        sleep_instruction <= 1'h0;
        clear_watchdog_instruction <= 1'h0;
    endtask

    initial begin
        repeat (12) @(posedge aclk);
        aresetn <= 1'h1;
        rd(32'h0000_0000);
        chk(d, 32'h0000_0000);
        wr(32'h0000_0010, 32'h0000_00ff);
        chk(r, 2'h2);
        rd(32'h0000_0000);
        chk(d, 32'h0000_0000);
        wr(32'h0000_0000, 32'h0000_00ff);
        chk(r, 2'h0);
        rd(32'h0000_0000);
        chk(d, 32'h0000_000f);
        rd(32'h0000_0010);
        chk(r, 2'h2);
        wr(32'h0000_0000, 32'h0000_0000);
        tick(6);
        chk(nres, 0);
        $display("register test done");
        for (ps = 0; ps < 8; ps++) begin
            wr(32'h0000_0000, {ps[2:0], 1'b1});
            tick((4 << ps) - 1);
            pulse(ps[0]);
            tick((4 << ps) - 1);
            chk(nres, ps);
            tick(1);
            chk(nres, ps + 1);
        end
        rd(32'h0000_0004);
        chk(d, 32'h0000_0001);
        chk(irq, 1'h0);
        wr(32'h0000_0008, 32'h0000_0001);
        chk(irq, 1'h1);
        wr(32'h0000_0004, 32'h0000_0001);
        chk(irq, 1'h0);
        $display("postscale test done");
        @(posedge aclk) sleep_mode <= 1'h1;
        wr(32'h0000_0000, 32'h0000_0001);
        tick(4);
        chk(nwak, 1);
        chk(nres, 8);
        rd(32'h0000_0004);
        chk(d, 32'h0000_0002);
        chk(irq, 1'h0);
        @(posedge aclk) sleep_mode <= 1'h0;
        $display("sleep test done");
        @(posedge aclk) config_watchdog_on <= 1'h1;
        wr(32'h0000_0000, 32'h0000_000e);
        tick(31);
        chk(nres, 8);
        tick(1);
        chk(nres, 9);
        chk(ntsc, 10);
        rd(32'h0000_000c);
        chk(d, 32'h0000_0007);
        $display("configuration test done");
        wrap_up();
    end
endmodule // watchdog_timer_tb

// File: core/pin_synchronizer.v
`timescale 1ns/1ps

// Three-stage synchroniser; the output follows only once stages two and three agree
module pin_synchronizer (
    input  wire aclk,
    input  wire aresetn,
    input  wire pin,
    output reg  level
);

    reg stage1;
    reg stage2;
    reg stage3;

    always @(posedge aclk) begin
        if (!aresetn) begin
            stage1 <= 1'b0;
            stage2 <= 1'b0;
            stage3 <= 1'b0;
            level  <= 1'b0;
        end else begin
            stage1 <= pin;
            stage2 <= stage1;
            stage3 <= stage2;
            if (stage2 == stage3) begin
                level <= stage3;
            end
        end
    end

endmodule // pin_synchronizer

// File: core/watchdog_defines.vh
`ifndef WATCHDOG_DEFINES_VH
`define WATCHDOG_DEFINES_VH

// Register byte addresses
`define ADDR_WATCHDOG_CONTROL    4'h0
`define ADDR_EVENT_STATUS        4'h4
`define ADDR_EVENT_MASK          4'h8
`define ADDR_WATCHDOG_STATE      4'hC
`define ADDR_MSB                 3
`define ADDR_LSB                 2

// Watchdog control fields
`define CTRL_ON_BIT              0
`define CTRL_PS_MSB              3
`define CTRL_PS_LSB              1
`define CTRL_WIDTH               4
`define CTRL_RESET               4'h0

// Event bits
`define EVT_TIMEOUT_RESET_BIT    0
`define EVT_WAKEUP_BIT           1
`define EVT_WIDTH                2
`define EVT_RESET                2'h0

// Bus answers
`define RESP_OKAY                2'h0
`define RESP_SLVERR              2'h2

// Postscale select width and base count default
`define PS_WIDTH                 3
`define BASE_COUNT_DEFAULT       256
`define BASE_COUNT_WIDTH_DEFAULT 16

`endif

// File: core/watchdog_timer.v
// Function
// - Count ticks of a separate RC oscillator, so counting continues while the core sleeps.
// - Time-out in normal operation raises a watchdog device reset.
// - Time-out in sleep wakes the device instead of resetting it.
// - Every time-out clears the time-out status flag in the reset control register.
// - Configuration off by default leaves the watchdog under software control.
// - Configuration enable keeps the watchdog running; software cannot stop it.
// - Configuration enable makes the software control register be ignored entirely.
// - Configuration off: software enable bit 0 starts and stops the watchdog.
// - Configuration enable: postscale ratio comes from the configured postscale bits.
// - Configuration off: postscale ratio comes from control bits 3 to 1.
// - Postscale value n divides by two to the power n, 1:1 to 1:128.
// - Clear-watchdog or sleep instruction clears counter and postscaler; software must do so often.
// - Clear-watchdog zeroes the postscale count but keeps the postscale selection.
// - Control bits 7 to 4 read as zero and ignore writes.
`timescale 1ns/1ps
`include "watchdog_defines.vh"

module watchdog_timer #(
    parameter BASE_COUNT       = `BASE_COUNT_DEFAULT,
    parameter BASE_COUNT_WIDTH = `BASE_COUNT_WIDTH_DEFAULT
) (
    input  wire                   aclk,
    input  wire                   aresetn,
    // AXI4-Lite slave
    input  wire [31:0]            s_axi_awaddr,
    input  wire                   s_axi_awvalid,
    output wire                   s_axi_awready,
    input  wire [31:0]            s_axi_wdata,
    input  wire [3:0]             s_axi_wstrb,
    input  wire                   s_axi_wvalid,
    output wire                   s_axi_wready,
    output reg  [1:0]             s_axi_bresp,
    output reg                    s_axi_bvalid,
    input  wire                   s_axi_bready,
    input  wire [31:0]            s_axi_araddr,
    input  wire                   s_axi_arvalid,
    output wire                   s_axi_arready,
    output reg  [31:0]            s_axi_rdata,
    output reg  [1:0]             s_axi_rresp,
    output reg                    s_axi_rvalid,
    input  wire                   s_axi_rready,
    // Watchdog oscillator pin and core hooks
    input  wire                   rc_oscillator,
    input  wire                   clear_watchdog_instruction,
    input  wire                   sleep_instruction,
    input  wire                   sleep_mode,
    input  wire                   config_watchdog_on,
    input  wire [`PS_WIDTH-1:0]   configured_postscale_select,
    output reg                    watchdog_reset,
    output reg                    watchdog_wakeup,
    output reg                    timeout_status_clear,
    output wire                   irq
);

    localparam POST_WIDTH = 8;

    reg  [`CTRL_WIDTH-1:0]      watchdog_control;
    reg  [`EVT_WIDTH-1:0]       event_status;
    reg  [`EVT_WIDTH-1:0]       event_mask;
    reg  [BASE_COUNT_WIDTH-1:0] base_count;
    reg  [POST_WIDTH-1:0]       post_count;
    reg                         osc_last;
    wire                        osc_level;
    wire                        osc_tick;
    wire                        software_watchdog_on;
    wire [`PS_WIDTH-1:0]        software_postscale_select;
    wire                        running;
    wire [`PS_WIDTH-1:0]        postscale_select;
    wire [POST_WIDTH-1:0]       post_limit;
    wire                        base_wrap;
    wire                        timeout;
    wire                        clear_counters;
    wire                        write_go;
    wire                        read_go;
    wire [`ADDR_MSB:0]          waddr;
    wire [`ADDR_MSB:0]          raddr;
    wire [`EVT_WIDTH-1:0]       event_set;
    wire [`EVT_WIDTH-1:0]       event_clear;
    reg                         aw_held;
    reg                         w_held;
    reg  [31:0]                 held_awaddr;
    reg  [31:0]                 held_wdata;
    reg  [3:0]                  held_wstrb;
    wire                        aw_take;
    wire                        w_take;
    wire [31:0]                 wr_addr;
    wire [31:0]                 wr_data;
    wire [3:0]                  wr_strb;
    reg  [1:0]                  next_bresp;
    reg  [BASE_COUNT_WIDTH-1:0] next_base_count;
    reg  [POST_WIDTH-1:0]       next_post_count;
    reg                         next_watchdog_reset;
    reg                         next_watchdog_wakeup;
    reg                         next_timeout_status_clear;

    // The RC oscillator is sampled as a pin; the core clock must run faster than it
    pin_synchronizer u_osc_sync (
        .aclk    (aclk),
        .aresetn (aresetn),
        .pin     (rc_oscillator),
        .level   (osc_level)
    );

    assign osc_tick = osc_level & ~osc_last;

    assign software_watchdog_on      = watchdog_control[`CTRL_ON_BIT];
    assign software_postscale_select = watchdog_control[`CTRL_PS_MSB:`CTRL_PS_LSB];

    // Configuration enable overrides both software fields
    assign running          = config_watchdog_on | software_watchdog_on;
    assign postscale_select = config_watchdog_on ? configured_postscale_select
                                                 : software_postscale_select;
    assign post_limit       = {{(POST_WIDTH-1){1'b0}}, 1'b1} << postscale_select;

    assign base_wrap      = osc_tick && (base_count == BASE_COUNT - 1);
    assign timeout        = running && base_wrap && (post_count == post_limit - 1'b1);
    assign clear_counters = clear_watchdog_instruction | sleep_instruction;

    // Next counts; a stopped watchdog holds them unless a clear-watchdog or sleep instruction zeroes them
    always @* begin
        next_base_count = base_count;
        next_post_count = post_count;
        if (clear_counters || timeout) begin
            // Only the counts clear; the postscale selection stays put
            next_base_count = {BASE_COUNT_WIDTH{1'b0}};
            next_post_count = {POST_WIDTH{1'b0}};
        end else if (running && osc_tick) begin
            if (base_wrap) begin
                next_base_count = {BASE_COUNT_WIDTH{1'b0}};
                next_post_count = post_count + 1'b1;
            end else begin
                next_base_count = base_count + 1'b1;
            end
        end
    end

    always @(posedge aclk) begin
        if (!aresetn) begin
            osc_last   <= 1'b0;
            base_count <= {BASE_COUNT_WIDTH{1'b0}};
            post_count <= {POST_WIDTH{1'b0}};
        end else begin
            osc_last   <= osc_level;
            base_count <= next_base_count;
            post_count <= next_post_count;
        end
    end

    // Time-out outcome: reset when awake, wake-up when asleep
    always @* begin
        next_watchdog_reset       = timeout && !sleep_mode;
        next_watchdog_wakeup      = timeout && sleep_mode;
        next_timeout_status_clear = timeout;
    end

    always @(posedge aclk) begin
        if (!aresetn) begin
            watchdog_reset       <= 1'b0;
            watchdog_wakeup      <= 1'b0;
            timeout_status_clear <= 1'b0;
        end else begin
            watchdog_reset       <= next_watchdog_reset;
            watchdog_wakeup      <= next_watchdog_wakeup;
            timeout_status_clear <= next_timeout_status_clear;
        end
    end

    // Address and data may arrive in either order; each is parked until its partner comes
    assign s_axi_awready = !aw_held && !s_axi_bvalid;
    assign s_axi_wready  = !w_held && !s_axi_bvalid;
    assign aw_take       = s_axi_awvalid && s_axi_awready;
    assign w_take        = s_axi_wvalid && s_axi_wready;
    assign write_go      = (aw_held || aw_take) && (w_held || w_take);
    assign wr_addr       = aw_held ? held_awaddr : s_axi_awaddr;
    assign wr_data       = w_held ? held_wdata : s_axi_wdata;
    assign wr_strb       = w_held ? held_wstrb : s_axi_wstrb;
    assign read_go       = s_axi_arvalid && !s_axi_rvalid;
    assign s_axi_arready = read_go;
    assign waddr         = wr_addr[`ADDR_MSB:0];
    assign raddr         = s_axi_araddr[`ADDR_MSB:0];

    always @(posedge aclk) begin
        if (!aresetn) begin
            aw_held     <= 1'b0;
            w_held      <= 1'b0;
            held_awaddr <= 32'h0000_0000;
            held_wdata  <= 32'h0000_0000;
            held_wstrb  <= 4'h0;
        end else if (write_go) begin
            aw_held <= 1'b0;
            w_held  <= 1'b0;
        end else begin
            if (aw_take) begin
                aw_held     <= 1'b1;
                held_awaddr <= s_axi_awaddr;
            end
            if (w_take) begin
                w_held     <= 1'b1;
                held_wdata <= s_axi_wdata;
                held_wstrb <= s_axi_wstrb;
            end
        end
    end

    // Unmapped or high addresses answer with an error and change nothing
    always @* begin
        next_bresp = `RESP_OKAY;
        case (waddr)
            `ADDR_WATCHDOG_CONTROL: next_bresp = `RESP_OKAY;
            `ADDR_EVENT_STATUS:     next_bresp = `RESP_OKAY;
            `ADDR_EVENT_MASK:       next_bresp = `RESP_OKAY;
            `ADDR_WATCHDOG_STATE:   next_bresp = `RESP_OKAY;
            default:                next_bresp = `RESP_SLVERR;
        endcase
        if (wr_addr[31:`ADDR_MSB+1] != 0) begin
            next_bresp = `RESP_SLVERR;
        end
    end

    assign event_set   = {watchdog_wakeup, watchdog_reset};
    assign event_clear = (write_go && wr_strb[0] && next_bresp == `RESP_OKAY && waddr == `ADDR_EVENT_STATUS)
                         ? wr_data[`EVT_WIDTH-1:0] : `EVT_RESET;

    always @(posedge aclk) begin
        if (!aresetn) begin
            watchdog_control <= `CTRL_RESET;
            event_mask       <= `EVT_RESET;
            event_status     <= `EVT_RESET;
            s_axi_bvalid     <= 1'b0;
            s_axi_bresp      <= `RESP_OKAY;
        end else begin
            // A new event wins over a clear in the same cycle
            event_status <= (event_status & ~event_clear) | event_set;
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
            if (write_go) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= next_bresp;
                case (waddr)
                    `ADDR_WATCHDOG_CONTROL: begin
                        if (wr_strb[0] && next_bresp == `RESP_OKAY) begin
                            watchdog_control <= wr_data[`CTRL_WIDTH-1:0];
                        end
                    end
                    `ADDR_EVENT_MASK: begin
                        if (wr_strb[0] && next_bresp == `RESP_OKAY) begin
                            event_mask <= wr_data[`EVT_WIDTH-1:0];
                        end
                    end
                    default: begin
                        // Status clears go through event_clear; other targets hold nothing
                    end
                endcase
            end
        end
    end

    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0000_0000;
            s_axi_rresp  <= `RESP_OKAY;
        end else begin
            if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
            if (read_go) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp  <= `RESP_OKAY;
                s_axi_rdata  <= 32'h0000_0000;
                case (raddr)
                    `ADDR_WATCHDOG_CONTROL: begin
                        // Upper bits stay zero
                        s_axi_rdata[`CTRL_WIDTH-1:0] <= watchdog_control;
                    end
                    `ADDR_EVENT_STATUS: begin
                        s_axi_rdata[`EVT_WIDTH-1:0] <= event_status;
                    end
                    `ADDR_EVENT_MASK: begin
                        s_axi_rdata[`EVT_WIDTH-1:0] <= event_mask;
                    end
                    `ADDR_WATCHDOG_STATE: begin
                        s_axi_rdata[0]     <= running;
                        s_axi_rdata[3:1]   <= postscale_select;
                        s_axi_rdata[15:8]  <= post_count;
                        s_axi_rdata[31:16] <= base_count[15:0];
                    end
                    default: begin
                        s_axi_rresp <= `RESP_SLVERR;
                    end
                endcase
                if (s_axi_araddr[31:`ADDR_MSB+1] != 0) begin
                    s_axi_rresp <= `RESP_SLVERR;
                end
            end
        end
    end

    assign irq = |(event_status & event_mask);

endmodule // watchdog_timer
